// >>> hw/cfg_word_reg.sv
/*
  one 16-bit configuration word with a factory value, host write and a
  load port for restoring from storage.
  assumes the caller never asserts host write and load in the same cycle;
  load wins if it does.
*/
`timescale 1ns/1ns
module cfg_word_reg #(
  parameter logic [15:0] RESET_VAL = 16'h0000,   // factory value
  parameter int          WIDTH     = 16          // live bits of the word
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        ce,
  input  wire logic        hostWe,
  input  wire logic [15:0] hostData,
  input  wire logic        loadEn,
  input  wire logic [15:0] loadData,
  output      logic [15:0] value
);

  // refuse widths that the masks below cannot express
  if (WIDTH < 1 || WIDTH > 16) begin : gBadWidth
    $error("cfg_word_reg width out of range");
  end

  // bits above the live width stay as in the factory value
  localparam logic [15:0] KEEP_MASK = 16'hffff >> WIDTH;
  localparam logic [15:0] LIVE_MASK = ~(KEEP_MASK << WIDTH);

  logic [15:0] srcWord;                         // word selected for update
  assign srcWord = loadEn ? loadData : hostData;

  // ---------------------------------------------------------------------------
  // storage
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      value <= RESET_VAL;
    end else if (ce && (loadEn || hostWe)) begin
      value <= (srcWord & LIVE_MASK) | (RESET_VAL & ~LIVE_MASK);
    end
  end

endmodule // cfg_word_reg

// >>> hw/servo_cfg_pkg.sv
/*
  shared constants of the servo drive configuration register bank:
  register addresses, reset values and command codes.
  assumes a frame decoder in front that turns each host write or read into a
  one-cycle request carrying a register address and a 16-bit word.
*/
package servo_cfg_pkg;

  // ---------------------------------------------------------------------------
  // widths
  // ---------------------------------------------------------------------------
  localparam int ADDR_W = 8;                        // register address width
  localparam int DATA_W = 16;                       // register word width

  // ---------------------------------------------------------------------------
  // register addresses
  // ---------------------------------------------------------------------------
  localparam logic [7:0] ADDR_SAVE_CMD    = 8'h00;  // save command word
  localparam logic [7:0] ADDR_DEV_STATUS  = 8'h01;  // device_address_status
  localparam logic [7:0] ADDR_IN_CONTROL  = 8'h02;  // input_control
  localparam logic [7:0] ADDR_IN_MODE     = 8'h03;  // input_mode
  localparam logic [7:0] ADDR_VP_GAIN     = 8'h04;  // velocity_proportional_gain
  localparam logic [7:0] ADDR_VI_GAIN     = 8'h06;  // velocity_integral_gain
  localparam logic [7:0] ADDR_VF_GAIN     = 8'h08;  // velocity_feedforward_gain
  localparam logic [7:0] ADDR_LINES       = 8'h0a;  // encoder_lines_per_turn
  localparam logic [7:0] ADDR_ACCEL       = 8'h0c;  // profile_acceleration
  localparam logic [7:0] ADDR_SPEED       = 8'h0e;  // profile_speed
  localparam logic [7:0] ADDR_CMD_LOW     = 8'h10;  // position_command_low
  localparam logic [7:0] ADDR_CMD_HIGH    = 8'h12;  // position_command_high
  localparam logic [7:0] ADDR_POS_LOW     = 8'h14;  // position_feedback_low
  localparam logic [7:0] ADDR_POS_HIGH    = 8'h16;  // position_feedback_high
  localparam logic [7:0] ADDR_SPD_FB      = 8'h18;  // speed_feedback

  // ---------------------------------------------------------------------------
  // factory values
  // ---------------------------------------------------------------------------
  localparam logic [15:0] RST_DEV_STATUS  = 16'h0007;
  localparam logic [15:0] RST_IN_CONTROL  = 16'h0000;
  localparam logic [15:0] RST_IN_MODE     = 16'h2000;
  localparam logic [15:0] RST_VP_GAIN     = 16'hff20;
  localparam logic [15:0] RST_VI_GAIN     = 16'hff10;
  localparam logic [15:0] RST_VF_GAIN     = 16'hff20;
  localparam logic [15:0] RST_LINES       = 16'h014e;
  localparam logic [15:0] RST_ACCEL       = 16'h4e20;
  localparam logic [15:0] RST_SPEED       = 16'h0800;
  localparam logic [15:0] RST_CMD         = 16'h0000;
  localparam logic [15:0] RST_SPD_FB      = 16'h0048;

  // ---------------------------------------------------------------------------
  // command codes and field positions
  // ---------------------------------------------------------------------------
  localparam logic [7:0]  SAVE_KEY_LOW    = 8'hff;  // low byte of save word, ignored
  localparam logic [15:0] POS_MODE_RUN    = 16'h0201; // position mode, motor on
  localparam logic [15:0] FACTORY_TRIGGER = 16'h0000; // value at gain reg meaning factory
  localparam int          NUM_SETTINGS    = 10;     // words held in storage image
  localparam logic [7:0]  DEFAULT_SLAVE   = 8'h07;  // slave id used when no strap

  // storage image slot indices
  localparam logic [3:0] SLOT_CONTROL = 4'h0;
  localparam logic [3:0] SLOT_MODE    = 4'h1;
  localparam logic [3:0] SLOT_VP      = 4'h2;
  localparam logic [3:0] SLOT_VI      = 4'h3;
  localparam logic [3:0] SLOT_VF      = 4'h4;
  localparam logic [3:0] SLOT_LINES   = 4'h5;
  localparam logic [3:0] SLOT_ACCEL   = 4'h6;
  localparam logic [3:0] SLOT_SPEED   = 4'h7;
  localparam logic [3:0] SLOT_CMDLO   = 4'h8;
  localparam logic [3:0] SLOT_CMDHI   = 4'h9;

  // copy engine states
  typedef enum logic [1:0] {
    COPY_IDLE = 2'b00,
    COPY_LOAD = 2'b01,
    COPY_SAVE = 2'b10
  } copy_state_t;

endpackage

// >>> hw/servo_cfg_regs.sv
/*
  configuration register bank of a dc servo drive: control and mode, loop
  gains, encoder lines, motion profile, 32-bit position command and read-back
  feedback, plus a save engine that copies settings into storage and a
  power-up engine that restores them.
  assumes a frame decoder delivers one-cycle write/read requests on clk, and
  the servo loop supplies feedback on the same clock.
*/
`timescale 1ns/1ns

module servo_cfg_regs #(
  parameter int NUM_SLOTS = servo_cfg_pkg::NUM_SETTINGS  // storage words
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        ce,            // freezes all state while low
  input  wire logic        powerUp,       // pulse: drive power-up, load store
  input  wire logic [7:0]  slaveId,       // own slave id from decoder
  input  wire logic        wrReq,         // pulse: host write
  input  wire logic        rdReq,         // pulse: host read
  input  wire logic [7:0]  regAddr,
  input  wire logic [15:0] wrData,
  input  wire logic [31:0] posMeasured,   // from servo loop
  input  wire logic [15:0] speedMeasured, // from servo loop
  output      logic [15:0] rdData,
  output      logic        rdValid,
  output      logic        rdError,       // unmapped address on read
  output      logic        busy,          // save or load walk running
  output      logic        motorEnable,
  output      logic        positionMode,
  output      logic [31:0] posCommandSteps,
  output      logic [15:0] linesPerTurn,
  output      logic [7:0]  vpGain,
  output      logic [7:0]  viGain,
  output      logic [7:0]  vfGain,
  output      logic [15:0] accelOut,
  output      logic [15:0] speedOut,
  output      logic [15:0] controlOut,
  output      logic [15:0] modeOut
);

  // the slot tables below are written out for exactly this many words
  if (NUM_SLOTS != servo_cfg_pkg::NUM_SETTINGS) begin : gBadSlots
    $error("slot count must match settings");
  end

  // ---------------------------------------------------------------------------
  // address decode
  // ---------------------------------------------------------------------------
  // writes are refused while a copy walk runs so the image stays coherent
  wire hostWr    = ce && wrReq && !busy;
  wire wrSave    = hostWr && regAddr == servo_cfg_pkg::ADDR_SAVE_CMD
                   && wrData[15:8] == slaveId;
  wire wrControl = hostWr && regAddr == servo_cfg_pkg::ADDR_IN_CONTROL;
  wire wrMode    = hostWr && regAddr == servo_cfg_pkg::ADDR_IN_MODE;
  wire wrVp      = hostWr && regAddr == servo_cfg_pkg::ADDR_VP_GAIN;
  wire wrVi      = hostWr && regAddr == servo_cfg_pkg::ADDR_VI_GAIN;
  wire wrVf      = hostWr && regAddr == servo_cfg_pkg::ADDR_VF_GAIN;
  wire wrLines   = hostWr && regAddr == servo_cfg_pkg::ADDR_LINES;
  wire wrAccel   = hostWr && regAddr == servo_cfg_pkg::ADDR_ACCEL;
  wire wrSpeed   = hostWr && regAddr == servo_cfg_pkg::ADDR_SPEED;
  wire wrCmdLo   = hostWr && regAddr == servo_cfg_pkg::ADDR_CMD_LOW;
  wire wrCmdHi   = hostWr && regAddr == servo_cfg_pkg::ADDR_CMD_HIGH;

  // ---------------------------------------------------------------------------
  // copy engine state
  // ---------------------------------------------------------------------------
  servo_cfg_pkg::copy_state_t copyState_reg, copyState_next;
  logic [3:0]  copyIdx_reg, copyIdx_next;       // slot being copied
  logic        factory_reg;                     // saved image asks for factory values
  logic        factory_next;

  wire         loading = copyState_reg == servo_cfg_pkg::COPY_LOAD;
  wire         saving  = copyState_reg == servo_cfg_pkg::COPY_SAVE;
  wire         lastIdx = copyIdx_reg == 4'(NUM_SLOTS - 1);
  wire  [15:0] imgWord;
  wire         imgValid;
  wire  [15:0] liveWord;

  // per-slot load strobes; a factory image holds the reset values, so a load
  // brings those back
  wire         doLoad = loading && imgValid;
  function automatic logic slotLd(input logic [3:0] s);
    slotLd = doLoad && copyIdx_reg == s;
  endfunction

  // ---------------------------------------------------------------------------
  // configuration words
  // ---------------------------------------------------------------------------
  logic [15:0] ctrlW, modeW, vpW, viW, vfW, linesW, accelW, speedW, cmdLoW, cmdHiW;

  // control keeps its whole word: the upper byte picks the mode, so 0201 must survive
  cfg_word_reg #(.RESET_VAL(servo_cfg_pkg::RST_IN_CONTROL), .WIDTH(16)) uCtrl (
    .clk(clk), .rst_n(rst_n), .ce(ce), .hostWe(wrControl), .hostData(wrData),
    .loadEn(slotLd(servo_cfg_pkg::SLOT_CONTROL)), .loadData(imgWord), .value(ctrlW));
  cfg_word_reg #(.RESET_VAL(servo_cfg_pkg::RST_IN_MODE), .WIDTH(8)) uMode (
    .clk(clk), .rst_n(rst_n), .ce(ce), .hostWe(wrMode), .hostData(wrData),
    .loadEn(slotLd(servo_cfg_pkg::SLOT_MODE)), .loadData(imgWord), .value(modeW));
  cfg_word_reg #(.RESET_VAL(servo_cfg_pkg::RST_VP_GAIN), .WIDTH(8)) uVp (
    .clk(clk), .rst_n(rst_n), .ce(ce), .hostWe(wrVp), .hostData(wrData),
    .loadEn(slotLd(servo_cfg_pkg::SLOT_VP)), .loadData(imgWord), .value(vpW));
  cfg_word_reg #(.RESET_VAL(servo_cfg_pkg::RST_VI_GAIN), .WIDTH(8)) uVi (
    .clk(clk), .rst_n(rst_n), .ce(ce), .hostWe(wrVi), .hostData(wrData),
    .loadEn(slotLd(servo_cfg_pkg::SLOT_VI)), .loadData(imgWord), .value(viW));
  // feedforward gain keeps the ff upper byte, only the low 8 bits are live
  cfg_word_reg #(.RESET_VAL(servo_cfg_pkg::RST_VF_GAIN), .WIDTH(8)) uVf (
    .clk(clk), .rst_n(rst_n), .ce(ce), .hostWe(wrVf), .hostData(wrData),
    .loadEn(slotLd(servo_cfg_pkg::SLOT_VF)), .loadData(imgWord), .value(vfW));
  cfg_word_reg #(.RESET_VAL(servo_cfg_pkg::RST_LINES), .WIDTH(16)) uLines (
    .clk(clk), .rst_n(rst_n), .ce(ce), .hostWe(wrLines), .hostData(wrData),
    .loadEn(slotLd(servo_cfg_pkg::SLOT_LINES)), .loadData(imgWord), .value(linesW));
  cfg_word_reg #(.RESET_VAL(servo_cfg_pkg::RST_ACCEL), .WIDTH(16)) uAccel (
    .clk(clk), .rst_n(rst_n), .ce(ce), .hostWe(wrAccel), .hostData(wrData),
    .loadEn(slotLd(servo_cfg_pkg::SLOT_ACCEL)), .loadData(imgWord), .value(accelW));
  cfg_word_reg #(.RESET_VAL(servo_cfg_pkg::RST_SPEED), .WIDTH(16)) uSpeed (
    .clk(clk), .rst_n(rst_n), .ce(ce), .hostWe(wrSpeed), .hostData(wrData),
    .loadEn(slotLd(servo_cfg_pkg::SLOT_SPEED)), .loadData(imgWord), .value(speedW));
  cfg_word_reg #(.RESET_VAL(servo_cfg_pkg::RST_CMD), .WIDTH(16)) uCmdLo (
    .clk(clk), .rst_n(rst_n), .ce(ce), .hostWe(wrCmdLo), .hostData(wrData),
    .loadEn(slotLd(servo_cfg_pkg::SLOT_CMDLO)), .loadData(imgWord), .value(cmdLoW));
  cfg_word_reg #(.RESET_VAL(servo_cfg_pkg::RST_CMD), .WIDTH(16)) uCmdHi (
    .clk(clk), .rst_n(rst_n), .ce(ce), .hostWe(wrCmdHi), .hostData(wrData),
    .loadEn(slotLd(servo_cfg_pkg::SLOT_CMDHI)), .loadData(imgWord), .value(cmdHiW));

  // ---------------------------------------------------------------------------
  // storage image and walk
  // ---------------------------------------------------------------------------
  // word offered to storage during a save walk, indexed by slot
  wire [15:0] liveTab [10] = '{ctrlW, modeW, vpW, viW, vfW, linesW, accelW, speedW, cmdLoW, cmdHiW};
  // factory words, stored instead of the live ones when the save is a factory restore
  wire [15:0] rstTab [10] = '{servo_cfg_pkg::RST_IN_CONTROL, servo_cfg_pkg::RST_IN_MODE,
                              servo_cfg_pkg::RST_VP_GAIN, servo_cfg_pkg::RST_VI_GAIN,
                              servo_cfg_pkg::RST_VF_GAIN, servo_cfg_pkg::RST_LINES,
                              servo_cfg_pkg::RST_ACCEL, servo_cfg_pkg::RST_SPEED,
                              servo_cfg_pkg::RST_CMD, servo_cfg_pkg::RST_CMD};
  assign liveWord = factory_reg ? rstTab[copyIdx_reg] : liveTab[copyIdx_reg];

  settings_store #(.SLOTS(NUM_SLOTS)) uStore (
    .clk(clk), .rst_n(rst_n), .ce(ce),
    .wrEn(saving), .wrIdx(copyIdx_reg), .wrData(liveWord),
    .markValid(saving && lastIdx),
    .rdIdx(copyIdx_reg), .rdData(imgWord), .imageValid(imgValid));

  // a zero proportional gain at save time marks the image as factory
  always_comb begin
    copyState_next = copyState_reg;
    copyIdx_next   = copyIdx_reg;
    factory_next   = factory_reg;
    case (copyState_reg)
      servo_cfg_pkg::COPY_IDLE: begin
        if (ce && powerUp) begin
          copyState_next = servo_cfg_pkg::COPY_LOAD;
          copyIdx_next   = 4'h0;
        end else if (wrSave) begin
          copyState_next = servo_cfg_pkg::COPY_SAVE;
          copyIdx_next   = 4'h0;
          // only the low byte of the gain is live; the upper byte stays ff
          factory_next   = vpW[7:0] == servo_cfg_pkg::FACTORY_TRIGGER[7:0];
        end
      end
      servo_cfg_pkg::COPY_LOAD, servo_cfg_pkg::COPY_SAVE: begin
        if (lastIdx) copyState_next = servo_cfg_pkg::COPY_IDLE;
        else copyIdx_next = copyIdx_reg + 4'h1;
      end
      default: copyState_next = servo_cfg_pkg::COPY_IDLE;
    endcase
  end

  // factory flag survives power-up the same way the image does
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      copyState_reg <= servo_cfg_pkg::COPY_IDLE;
      copyIdx_reg   <= 4'h0;
      factory_reg   <= 1'b0;
    end else if (ce) begin
      copyState_reg <= copyState_next;
      copyIdx_reg   <= copyIdx_next;
      factory_reg   <= factory_next;
    end
  end

  // ---------------------------------------------------------------------------
  // read path
  // ---------------------------------------------------------------------------
  wire        modeOn = ctrlW[7:0] != 8'h00;
  wire [15:0] statusWord = {7'h00, modeOn, slaveId};
  logic [15:0] rdMux;
  logic        rdHit;

  always_comb begin
    rdHit = 1'b1;
    case (regAddr)
      servo_cfg_pkg::ADDR_DEV_STATUS: rdMux = statusWord;
      servo_cfg_pkg::ADDR_IN_CONTROL: rdMux = ctrlW;
      servo_cfg_pkg::ADDR_IN_MODE:    rdMux = modeW;
      servo_cfg_pkg::ADDR_VP_GAIN:    rdMux = vpW;
      servo_cfg_pkg::ADDR_VI_GAIN:    rdMux = viW;
      servo_cfg_pkg::ADDR_VF_GAIN:    rdMux = vfW;
      servo_cfg_pkg::ADDR_LINES:      rdMux = linesW;
      servo_cfg_pkg::ADDR_ACCEL:      rdMux = accelW;
      servo_cfg_pkg::ADDR_SPEED:      rdMux = speedW;
      servo_cfg_pkg::ADDR_CMD_LOW:    rdMux = cmdLoW;
      servo_cfg_pkg::ADDR_CMD_HIGH:   rdMux = cmdHiW;
      servo_cfg_pkg::ADDR_POS_LOW:    rdMux = posMeasured[15:0];
      servo_cfg_pkg::ADDR_POS_HIGH:   rdMux = posMeasured[31:16];
      servo_cfg_pkg::ADDR_SPD_FB:     rdMux = speedMeasured;
      default: begin
        rdMux = 16'h0000;
        rdHit = 1'b0;
      end
    endcase
  end

  // read answer registered one cycle after the request
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdData  <= 16'h0000;
      rdValid <= 1'b0;
      rdError <= 1'b0;
    end else if (ce) begin
      rdValid <= rdReq;
      rdError <= rdReq && !rdHit;
      if (rdReq) rdData <= rdMux;
    end
  end

  // ---------------------------------------------------------------------------
  // outputs to the servo loop, all registered
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busy            <= 1'b0;
      motorEnable     <= 1'b0;
      positionMode    <= 1'b0;
      posCommandSteps <= 32'h0000_0000;
      linesPerTurn    <= servo_cfg_pkg::RST_LINES;
      vpGain          <= servo_cfg_pkg::RST_VP_GAIN[7:0];
      viGain          <= servo_cfg_pkg::RST_VI_GAIN[7:0];
      vfGain          <= servo_cfg_pkg::RST_VF_GAIN[7:0];
      accelOut        <= servo_cfg_pkg::RST_ACCEL;
      speedOut        <= servo_cfg_pkg::RST_SPEED;
      controlOut      <= servo_cfg_pkg::RST_IN_CONTROL;
      modeOut         <= servo_cfg_pkg::RST_IN_MODE;
    end else if (ce) begin
      busy            <= copyState_next != servo_cfg_pkg::COPY_IDLE;
      motorEnable     <= ctrlW[0];
      positionMode    <= ctrlW == servo_cfg_pkg::POS_MODE_RUN;
      posCommandSteps <= {cmdHiW, cmdLoW};
      linesPerTurn    <= linesW;
      vpGain          <= vpW[7:0];
      viGain          <= viW[7:0];
      vfGain          <= vfW[7:0];
      accelOut        <= accelW;
      speedOut        <= speedW;
      controlOut      <= ctrlW;
      modeOut         <= modeW;
    end
  end

endmodule // servo_cfg_regs

// >>> hw/settings_store.sv
/*
  nonvolatile settings image, modelled as flip-flops that survive the
  soft power-up request but not the chip reset. holds a valid flag so that a
  blank store is never loaded.
  assumes the surrounding chip keeps this block powered across a drive power
  cycle, which is what the power-up request stands for.
*/
`timescale 1ns/1ns
module settings_store #(
  parameter int SLOTS = 10                      // words in the image
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        ce,
  input  wire logic        wrEn,
  input  wire logic [3:0]  wrIdx,
  input  wire logic [15:0] wrData,
  input  wire logic        markValid,
  input  wire logic [3:0]  rdIdx,
  output      logic [15:0] rdData,
  output      logic        imageValid
);

  // a 4-bit index reaches sixteen slots at most
  if (SLOTS < 1 || SLOTS > 16) begin : gBadSlots
    $error("settings_store slots out of range");
  end

  logic [15:0] mem [SLOTS];                     // image words

  // read is combinational so a load walk takes one word per cycle
  assign rdData = (int'(rdIdx) < SLOTS) ? mem[rdIdx] : 16'h0000;

  // ---------------------------------------------------------------------------
  // writes
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < SLOTS; i++) mem[i] <= 16'h0000;
      imageValid <= 1'b0;
    end else if (ce) begin
      if (wrEn && int'(wrIdx) < SLOTS) mem[wrIdx] <= wrData;
      if (markValid) imageValid <= 1'b1;
    end
  end

endmodule // settings_store

// >>> tb/host_master_model.sv
/*
  host master model: one-cycle register requests from task calls.
  assumes framing is decoded already; drives on the falling edge.
*/
`timescale 1ns/1ns
module host_master_model (
  input  wire logic        clk,
  input  wire logic        rdValid,
  input  wire logic        rdError,
  input  wire logic [15:0] rdData,
  output      logic        wrReq,
  output      logic        rdReq,
  output      logic [7:0]  regAddr,
  output      logic [15:0] wrData
);
  initial begin
    wrReq   = 1'b0;
    rdReq   = 1'b0;
    regAddr = 8'h00;
    wrData  = 16'h0000;
  end
  // save word is {slave id, don't care}; command halves go singly
  task automatic writeReg(input logic [7:0] a, input logic [15:0] d);
    @(negedge clk);
    regAddr = a;
    wrData  = d;
    wrReq   = 1'b1;
    @(negedge clk);
    wrReq   = 1'b0;
    wrData  = ~d; // stale data must not pass for a hold
  endtask
  // answer is due one cycle after the request; a missing one reads dead
  task automatic readReg(input logic [7:0] a, output logic [15:0] d, output logic e);
    @(negedge clk);
    regAddr = a;
    rdReq   = 1'b1;
    @(negedge clk);
    rdReq   = 1'b0;
    d = rdValid ? rdData : 16'hdead;
    e = rdError;
  endtask
endmodule // host_master_model

// >>> tb/servo_cfg_regs_chk.sv
/*
  concurrent checks on the servo configuration register bank ports.
  assumes it is bound onto servo_cfg_regs and that ce stays high.
*/
`timescale 1ns/1ns
module servo_cfg_regs_chk (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        ce,
  input wire logic        powerUp,
  input wire logic [7:0]  slaveId,
  input wire logic        wrReq,
  input wire logic        rdReq,
  input wire logic [7:0]  regAddr,
  input wire logic [15:0] wrData,
  input wire logic [31:0] posMeasured,
  input wire logic [15:0] speedMeasured,
  input wire logic [15:0] rdData,
  input wire logic        rdValid,
  input wire logic        busy,
  input wire logic        positionMode,
  input wire logic [7:0]  vfGain,
  input wire logic [31:0] posCommandSteps
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // an accepted write: a write while busy is dropped; writes in a power-up cycle are left out here
  sequence s_wr(logic [7:0] a);
    ce && wrReq && !busy && !powerUp && regAddr == a;
  endsequence
  sequence s_rd(logic [7:0] a);
    ce && rdReq && regAddr == a;
  endsequence
  // outputs follow a write two edges after it is taken
  property p_rd_valid; ce && rdReq |=> rdValid; endproperty
  a_rd_valid: assert property (p_rd_valid) else $error("read answer missing");
  property p_save; s_wr(8'h00) ##0 wrData[15:8] == slaveId |=> busy [*8]; endproperty
  a_save: assert property (p_save) else $error("save walk not started");
  property p_save_id; s_wr(8'h00) ##0 wrData[15:8] != slaveId |=> !busy; endproperty
  a_save_id: assert property (p_save_id) else $error("save with foreign id taken");
  property p_mode; s_wr(8'h02) ##0 wrData == 16'h0201 |=> ##1 positionMode; endproperty
  a_mode: assert property (p_mode) else $error("position mode not entered");
  property p_cmd_lo; s_wr(8'h10) |=> ##1 posCommandSteps[15:0] == $past(wrData, 2); endproperty
  a_cmd_lo: assert property (p_cmd_lo) else $error("command low half wrong");
  property p_cmd_hi; s_wr(8'h12) |=> ##1 posCommandSteps[31:16] == $past(wrData, 2); endproperty
  a_cmd_hi: assert property (p_cmd_hi) else $error("command high half wrong");
  property p_vf; s_wr(8'h08) |=> ##1 {8'h00, vfGain} == ($past(wrData, 2) & 16'h00ff); endproperty
  a_vf: assert property (p_vf) else $error("feedforward gain wrong");
  property p_status; s_rd(8'h01) |=> rdData[7:0] == $past(slaveId); endproperty
  a_status: assert property (p_status) else $error("status id byte wrong");
  property p_pos_fb; s_rd(8'h14) |=> rdData == $past(posMeasured[15:0]); endproperty
  a_pos_fb: assert property (p_pos_fb) else $error("position feedback wrong");
  property p_spd_fb; s_rd(8'h18) |=> rdData == $past(speedMeasured); endproperty
  a_spd_fb: assert property (p_spd_fb) else $error("speed feedback wrong");
endmodule // servo_cfg_regs_chk
bind servo_cfg_regs servo_cfg_regs_chk servo_cfg_regs_chk_i (.*);

// >>> tb/servo_cfg_regs_tb.sv
/*
  self-checking bench of the servo configuration register bank.
  assumes a master model in front and feedback held at fixed levels.
*/
`timescale 1ns/1ns
module servo_cfg_regs_tb;
  logic        clk = 1'b0, rst_n = 1'b0, ce = 1'b1, powerUp = 1'b0;
  logic [7:0]  slaveId = 8'h07;
  logic [31:0] posMeasured = 32'h1234abcd;
  logic [15:0] speedMeasured = 16'h0321;
  logic        wrReq, rdReq, rdValid, rdError, busy, motorEnable, positionMode, ev;
  logic [7:0]  regAddr, vpGain, viGain, vfGain;
  logic [15:0] wrData, rdData, linesPerTurn, accelOut, speedOut, controlOut, modeOut, rv;
  logic [31:0] posCommandSteps;
  int          n_errors = 0;
  int          n_tests = 0;
  always #4 clk = ~clk;
  servo_cfg_regs servo_cfg_regs_i (.*);
  host_master_model host_master_model_i (.*);
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic rdChk(input string what, input logic [7:0] a, input logic [15:0] exp);
    host_master_model_i.readReg(a, rv, ev);
    check(what, {16'h0, rv}, {16'h0, exp});
  endtask
  // bounded wait for the save or load walk to finish
  task automatic waitIdle;
    repeat (20) if (busy === 1'b1) @(negedge clk);
    check("busy end", {31'h0, busy}, 32'h0);
  endtask
  // power-up pulse, then wait for the load walk
  task automatic pulsePower;
    powerUp = 1'b1;
    @(negedge clk);
    powerUp = 1'b0;
    waitIdle();
  endtask
  // chip reset, unlike the power-up pulse: it clears the stored image too
  task automatic doReset;
    rst_n = 1'b0;
    repeat (12) @(negedge clk);
    rst_n = 1'b1;
  endtask
  task automatic t_defaults;
    logic [7:0]  a [12] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h06, 8'h08, 8'h0a, 8'h0c, 8'h0e, 8'h10, 8'h12, 8'h18};
    logic [15:0] e [12] = '{16'h0007, 16'h0000, 16'h2000, 16'hff20, 16'hff10, 16'hff20, 16'h014e,
                            16'h4e20, 16'h0800, 16'h0000, 16'h0000, 16'h0321};
    for (int i = 0; i < 12; i++) rdChk("reset value", a[i], e[i]);
    rdChk("pos low", 8'h14, 16'habcd);
    rdChk("pos high", 8'h16, 16'h1234);
    rdChk("unmapped", 8'h05, 16'h0000);
    check("unmapped err", {31'h0, ev}, 32'h1);
    check("gain outs", {8'h0, vpGain, viGain, vfGain}, 32'h00201020);
    check("lines accel", {linesPerTurn, accelOut}, 32'h014e4e20);
    check("speed mode", {speedOut, modeOut}, 32'h08002000);
    $display("t_defaults done");
  endtask
  task automatic t_write;
    host_master_model_i.writeReg(8'h08, 16'h1234);
    rdChk("vf gain", 8'h08, 16'hff34);
    host_master_model_i.writeReg(8'h10, 16'hd5b0);
    host_master_model_i.writeReg(8'h12, 16'h0001);
    @(negedge clk);
    check("cmd steps", posCommandSteps, 32'h0001d5b0);
    host_master_model_i.writeReg(8'h02, 16'h0201);
    @(negedge clk);
    check("pos mode", {30'h0, positionMode, motorEnable}, 32'h3);
    check("ctl out", {16'h0, controlOut}, 32'h0201);
    rdChk("status", 8'h01, 16'h0107);
    host_master_model_i.writeReg(8'h18, 16'h5555);
    rdChk("speed ro", 8'h18, 16'h0321);
    host_master_model_i.writeReg(8'h14, 16'h5555);
    rdChk("pos ro", 8'h14, 16'habcd);
    $display("t_write done");
  endtask
  task automatic t_save;
    host_master_model_i.writeReg(8'h00, 16'h03ff);
    check("foreign id", {31'h0, busy}, 32'h0);
    host_master_model_i.writeReg(8'h00, 16'h07aa);
    check("save busy", {31'h0, busy}, 32'h1);
    waitIdle();
    host_master_model_i.writeReg(8'h08, 16'h0055);
    host_master_model_i.writeReg(8'h10, 16'h0000);
    rdChk("vf changed", 8'h08, 16'hff55);
    pulsePower();
    rdChk("vf restored", 8'h08, 16'hff34);
    check("cmd restored", posCommandSteps, 32'h0001d5b0);
    $display("t_save done");
  endtask
  task automatic t_factory;
    host_master_model_i.writeReg(8'h04, 16'h0000);
    host_master_model_i.writeReg(8'h00, 16'h07ff);
    waitIdle();
    host_master_model_i.writeReg(8'h08, 16'h0077);
    pulsePower();
    rdChk("vf factory", 8'h08, 16'hff20);
    rdChk("vp factory", 8'h04, 16'hff20);
    // mid-run reset clears the image: a later power-up must load nothing
    doReset();
    host_master_model_i.writeReg(8'h06, 16'h0033);
    pulsePower();
    rdChk("blank load", 8'h06, 16'hff33);
    $display("t_factory done");
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // watchdog: the tests need well under a tenth of this span
  initial begin
    #100000;
    n_errors++;
    complete_run();
  end
  initial begin
    doReset();
    t_defaults();
    t_write();
    t_save();
    t_factory();
    complete_run();
  end
endmodule // servo_cfg_regs_tb
